// file: hdl/ptxcp_port.sv
module ptxcp_port #(
    parameter int                            DW = 64,      // transmit word width
    parameter int                            READY_LATENCY = 2,
    parameter logic [ptxcp_pkg::DATA_CR_W-1:0] CPLD_LIMIT = 12'h040,
    parameter logic [ptxcp_pkg::DATA_CR_W-1:0] NPD_LIMIT = 12'h010,
    parameter logic [ptxcp_pkg::DATA_CR_W-1:0] PD_LIMIT = 12'h040,
    parameter logic [ptxcp_pkg::HDR_CR_W-1:0]  CPLH_LIMIT = 8'h10,
    parameter logic [ptxcp_pkg::HDR_CR_W-1:0]  NPH_LIMIT = 8'h10,
    parameter logic [ptxcp_pkg::HDR_CR_W-1:0]  PH_LIMIT = 8'h10,
    parameter logic [ptxcp_pkg::CR_TYPES-1:0]  UNLIMITED = 6'h03,
    parameter logic [ptxcp_pkg::HDR_CR_W-1:0]  CPLH_CAP = 8'h40,
    parameter logic [ptxcp_pkg::DATA_CR_W-1:0] CPLD_CAP = 12'h100
) (
    input  wire logic                            mclk,
    input  wire logic                            rst,
    input  wire logic [DW-1:0]                   transmit_word,
    input  wire logic                            transmit_valid,
    input  wire logic                            transmit_packet_start,
    input  wire logic                            transmit_packet_end,
    input  wire logic [1:0]                      transmit_upper_empty,
    output logic                                 transmit_ready,
    output logic [ptxcp_pkg::DATA_CR_W-1:0]      cpl_data_credit_limit,
    output logic [ptxcp_pkg::DATA_CR_W-1:0]      np_data_credit_limit,
    output logic [ptxcp_pkg::DATA_CR_W-1:0]      p_data_credit_limit,
    output logic [ptxcp_pkg::HDR_CR_W-1:0]       cpl_header_credit_limit,
    output logic [ptxcp_pkg::HDR_CR_W-1:0]       np_header_credit_limit,
    output logic [ptxcp_pkg::HDR_CR_W-1:0]       p_header_credit_limit,
    output logic [ptxcp_pkg::CR_TYPES-1:0]       credit_consumed,
    output logic [ptxcp_pkg::CR_TYPES-1:0]       credit_unlimited_flags,
    output logic [ptxcp_pkg::HDR_CR_W-1:0]       cpl_header_buffer_capacity,
    output logic [ptxcp_pkg::DATA_CR_W-1:0]      cpl_payload_buffer_capacity,
    output logic [DW-1:0]                        egress_word,
    output logic                                 egress_valid,
    output logic                                 egress_packet_start,
    output logic                                 egress_packet_end,
    output logic [1:0]                           egress_upper_empty,
    input  wire logic                            egress_ready
);
    import ptxcp_pkg::*;

    localparam int BW = DW + 4;               // word plus start, end, empty

    // credit class of the header in dword0, messages count as posted
    function automatic ptxcp_cls_t hdr_class(input logic [31:0] dw0);
        logic [4:0] typ;
        typ = dw0[TYPE_HI:TYPE_LO];
        if (typ == TYPE_CPL) begin
            hdr_class = PTXCP_CLS_CPL;
        end else if (typ == TYPE_MWR && dw0[FMT_DATA_BIT]) begin
            hdr_class = PTXCP_CLS_P;
        end else if (typ[4:3] == TYPE_CLASS_MSG) begin
            hdr_class = PTXCP_CLS_P;
        end else begin
            hdr_class = PTXCP_CLS_NP;
        end
    endfunction

    // header dword0 sits in the lowest dword, packets start at the bottom
    wire [31:0]      hdr_dw0 = transmit_word[31:0];
    wire ptxcp_cls_t sop_cls = hdr_class(hdr_dw0);
    wire             sop_has_data = hdr_dw0[FMT_DATA_BIT];
    wire [9:0]       sop_len_dw = hdr_dw0[9:0];

    // static limit and capacity outputs
    assign cpl_data_credit_limit = CPLD_LIMIT;
    assign np_data_credit_limit = NPD_LIMIT;
    assign p_data_credit_limit = PD_LIMIT;
    assign cpl_header_credit_limit = CPLH_LIMIT;
    assign np_header_credit_limit = NPH_LIMIT;
    assign p_header_credit_limit = PH_LIMIT;
    assign credit_unlimited_flags = UNLIMITED;
    assign cpl_header_buffer_capacity = CPLH_CAP;
    assign cpl_payload_buffer_capacity = CPLD_CAP;

    // ready pipeline: application sees ready, words land latency later
    logic [RDY_LAT_MAX-1:0] rdy_pipe;                    // ready history
    logic                   buf_in_ready;                // buffer space
    wire                    accept = transmit_valid;     // valid only in window cycles, latency after ready
    wire                    window = rdy_pipe[READY_LATENCY-1];

    // ready only when the two-deep buffer can absorb every word in flight;
    // holding ready low while empty costs two bubbles per word but avoids overflow
    assign transmit_ready = buf_in_ready && !rdy_pipe[0] && !rdy_pipe[RDY_LAT_MAX-1];

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdy_pipe <= '0;
        end else begin
            rdy_pipe <= {rdy_pipe[RDY_LAT_MAX-2:0], transmit_ready};
        end
    end

    // every taken start is charged, so a start right after an end
    // needs no idle cycle in between
    wire  take = accept && window;
    wire  take_start = take && transmit_packet_start;

    // credit charge on start: header and data in one cycle, or header alone
    logic [CR_TYPES-1:0] next_consumed;                  // pulse vector
    logic [CR_TYPES-1:0] cons_hdr;
    logic [CR_TYPES-1:0] cons_dat;
    assign cons_hdr = (sop_cls == PTXCP_CLS_P)   ? (6'h01 << CR_PH) :
                      (sop_cls == PTXCP_CLS_NP)  ? (6'h01 << CR_NPH) : (6'h01 << CR_CPLH);
    assign cons_dat = !sop_has_data ? 6'h00 :
                      (sop_cls == PTXCP_CLS_P)   ? (6'h01 << CR_PD) :
                      (sop_cls == PTXCP_CLS_NP)  ? (6'h01 << CR_NPD) : (6'h01 << CR_CPLD);
    assign next_consumed = take_start ? (cons_hdr | cons_dat) : 6'h00;

    // remaining data credits of a long payload, one per later cycle
    logic [9:0] data_cr_left;
    logic [CR_TYPES-1:0] data_bit;                       // data type of packet in charge
    // a zero length field means 1024 dwords; one extra bit avoids the wrap
    // payload alignment does not change the credit count
    wire  [10:0] sop_len_ext = (sop_len_dw == 10'h000) ? 11'h400 : {1'b0, sop_len_dw};
    wire  [9:0]  sop_data_cr = sop_has_data ?
                 10'((sop_len_ext + 11'(DW_PER_DATA_CR - 1)) / 11'(DW_PER_DATA_CR)) : 10'h000;

    always_ff @(posedge mclk) begin
        if (rst) begin
            credit_consumed <= '0;
            data_cr_left <= '0;
            data_bit <= '0;
        end else if (take_start) begin
            credit_consumed <= next_consumed;
            data_cr_left <= (sop_data_cr == 10'h000) ? 10'h000 : sop_data_cr - 10'h001;
            data_bit <= cons_dat;
        end else if (data_cr_left != 10'h000) begin
            credit_consumed <= data_bit;                  // data alone, header already taken
            data_cr_left <= data_cr_left - 10'h001;
        end else begin
            credit_consumed <= '0;
        end
    end

    // buffer in the data path toward the transaction layer
    ptxcp_buf #(
        .W(BW)
    ) u_buf (
        .mclk      (mclk),
        .rst       (rst),
        .in_data   ({transmit_upper_empty, transmit_packet_end, transmit_packet_start, transmit_word}),
        .in_valid  (take),
        .in_ready  (buf_in_ready),
        .out_data  ({egress_upper_empty, egress_packet_end, egress_packet_start, egress_word}),
        .out_valid (egress_valid),
        .out_ready (egress_ready)
    );

    // a word taken while buffer is full would be lost; ready gating prevents it
    property p_no_overflow;
        @(posedge mclk) disable iff (rst) take |-> buf_in_ready;
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("word taken while buffer full");
    // at most one header and one data credit type in a cycle
    property p_hdr_pair;
        @(posedge mclk) disable iff (rst)
            $countones(credit_consumed & 6'h2a) <= 1 && $countones(credit_consumed & 6'h15) <= 1;
    endproperty
    a_hdr_pair: assert property (p_hdr_pair) else $error("illegal credit combination");
    // a header pulse lasts one cycle unless another start follows at once
    property p_pulse_hdr;
        @(posedge mclk) disable iff (rst)
            (|(credit_consumed & 6'h2a)) |=> !(|(credit_consumed & 6'h2a)) || $past(take_start);
    endproperty
    a_pulse_hdr: assert property (p_pulse_hdr) else $error("header pulse too long");
    // every taken start is charged one cycle later
    property p_start_charges;
        @(posedge mclk) disable iff (rst) take_start |=> (|(credit_consumed & 6'h2a));
    endproperty
    a_start_charges: assert property (p_start_charges) else $error("start without header credit");
    // limits and capacities never move
    property p_limits_static;
        @(posedge mclk) disable iff (rst)
            ##1 $stable(p_data_credit_limit) && $stable(np_data_credit_limit) && $stable(cpl_data_credit_limit);
    endproperty
    a_limits_static: assert property (p_limits_static) else $error("limit changed");
    property p_hlimits_static;
        @(posedge mclk) disable iff (rst)
            ##1 $stable(np_header_credit_limit) && $stable(p_header_credit_limit) && $stable(cpl_header_credit_limit);
    endproperty
    a_hlimits_static: assert property (p_hlimits_static) else $error("header limit changed");
    property p_cap_static;
        @(posedge mclk) disable iff (rst) ##1 $stable(cpl_header_buffer_capacity);
    endproperty
    a_cap_static: assert property (p_cap_static) else $error("capacity changed");
    property p_dcap_static;
        @(posedge mclk) disable iff (rst) ##1 $stable(cpl_payload_buffer_capacity);
    endproperty
    a_dcap_static: assert property (p_dcap_static) else $error("payload capacity changed");
    // a taken word is offered downstream in the next cycle
    property p_taken_out;
        @(posedge mclk) disable iff (rst) take |=> egress_valid;
    endproperty
    a_taken_out: assert property (p_taken_out) else $error("taken word not offered");
endmodule

// file: hdl/ptxcp_pkg.sv
package ptxcp_pkg;
    // credit vector bit positions, shared by consumed and unlimited vectors
    localparam int CR_PH = 5;                  // posted header
    localparam int CR_PD = 4;                  // posted data
    localparam int CR_NPH = 3;                 // non-posted header
    localparam int CR_NPD = 2;                 // non-posted data
    localparam int CR_CPLH = 1;                // completion header
    localparam int CR_CPLD = 0;                // completion data
    localparam int CR_TYPES = 6;               // credit types
    localparam int DATA_CR_W = 12;             // data credit width
    localparam int HDR_CR_W = 8;               // header credit width
    localparam int DATA_CR_BYTES = 16;         // bytes per data credit
    localparam int HDR_CR_BYTES = 20;          // bytes per header credit
    localparam int DW_BYTES = 4;               // bytes per dword
    localparam int DW_PER_DATA_CR = DATA_CR_BYTES / DW_BYTES;
    localparam int RDY_LAT_MIN = 1;            // ready latency lower bound
    localparam int RDY_LAT_MAX = 2;            // ready latency upper bound
    localparam int FMT_DATA_BIT = 30;          // header dword0 fmt: has payload
    localparam int FMT_4DW_BIT = 29;           // header dword0 fmt: four dword header
    localparam int TYPE_LO = 24;               // header dword0 type field low bit
    localparam int TYPE_HI = 28;               // header dword0 type field high bit
    localparam logic [1:0] TYPE_CLASS_MSG = 2'h2; // type[4:3] = 2'b10 marks a message
    localparam logic [4:0] TYPE_CPL = 5'h0a;   // completion type code
    localparam logic [4:0] TYPE_MWR = 5'h00;   // memory write / read type code
    localparam logic [DATA_CR_W-1:0] RST_DATA_CR = 12'h000;
    localparam logic [HDR_CR_W-1:0] RST_HDR_CR = 8'h00;
    // credit class encoding of a packet
    typedef enum logic [1:0] {
        PTXCP_CLS_P   = 2'b00,
        PTXCP_CLS_NP  = 2'b01,
        PTXCP_CLS_CPL = 2'b10
    } ptxcp_cls_t;
endpackage

// file: hdl/ptxcp_buf.sv
// two-entry skid buffer; a stall downstream loses no word
module ptxcp_buf #(
    parameter int W = 64
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0] slot [2];        // storage entries
    logic         rd_ptr;          // oldest entry
    logic         wr_ptr;          // next free entry
    logic [1:0]   count;           // entries held
    wire          push = in_valid && in_ready;
    wire          pop = out_valid && out_ready;

    assign in_ready = (count != 2'h2);   // honest full
    assign out_valid = (count != 2'h0);  // honest empty
    assign out_data = slot[rd_ptr];

    // pointer and occupancy update
    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end

    // data store, no reset needed for payload
    always_ff @(posedge mclk) begin
        if (push) begin
            slot[wr_ptr] <= in_data;
        end
    end
endmodule

// file: testbench/ptxcp_app_model.sv
// application side: sends queued words only in ready cycles, latency two
module ptxcp_app_model (
    input  wire logic   mclk,
    input  wire logic   rst,
    input  wire logic   transmit_ready,
    output logic [63:0] transmit_word,
    output logic        transmit_valid,
    output logic        transmit_packet_start,
    output logic        transmit_packet_end,
    output logic [1:0]  transmit_upper_empty
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [67:0] pend[$];   // {upper_empty, start, end, word}
    logic [1:0]  hist;      // ready seen one and two cycles back

    initial begin
        hist = 2'h0;
        transmit_valid = 1'b0;
        {transmit_upper_empty, transmit_packet_start, transmit_packet_end, transmit_word} = 68'h0;
    end

    // valid only two cycles after a ready; otherwise drop valid, keep word
    always @(posedge mclk) begin
        hist = rst ? 2'h0 : {hist[0], transmit_ready};
        #1;
        if (hist[1] && pend.size() > 0 && !rst) begin
            {transmit_upper_empty, transmit_packet_start, transmit_packet_end, transmit_word} = pend.pop_front();
            transmit_valid = 1'b1;
        end else begin
            transmit_valid = 1'b0;   // word held while stalled
        end
    end
endmodule

// file: testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ptxcp_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic egress_ready = 1'b1;
    logic [63:0] transmit_word, egress_word;
    logic transmit_valid, transmit_packet_start, transmit_packet_end, transmit_ready;
    logic [1:0] transmit_upper_empty, egress_upper_empty;
    logic egress_valid, egress_packet_start, egress_packet_end;
    logic [11:0] cpld_lim, npd_lim, pd_lim, cpld_cap;
    logic [7:0] cplh_lim, nph_lim, ph_lim, cplh_cap;
    logic [5:0] credit_consumed, unl_flags;
    logic [67:0] expq[$];   // words expected at the egress side
    int cons_cnt[CR_TYPES];
    int failures = 0;
    int tests_run = 0;

    always #2 mclk = ~mclk;

    ptxcp_app_model app (.mclk(mclk), .rst(rst), .transmit_ready(transmit_ready), .transmit_word(transmit_word),
        .transmit_valid(transmit_valid), .transmit_packet_start(transmit_packet_start),
        .transmit_packet_end(transmit_packet_end), .transmit_upper_empty(transmit_upper_empty));

    ptxcp_port #(.PD_LIMIT(12'h678), .NPH_LIMIT(8'h34), .PH_LIMIT(8'h56), .UNLIMITED(6'h04),
        .CPLD_CAP(12'hbcd)) uut (.mclk(mclk), .rst(rst), .transmit_word(transmit_word),
        .transmit_valid(transmit_valid), .transmit_packet_start(transmit_packet_start),
        .transmit_packet_end(transmit_packet_end), .transmit_upper_empty(transmit_upper_empty),
        .transmit_ready(transmit_ready), .cpl_data_credit_limit(cpld_lim), .np_data_credit_limit(npd_lim),
        .p_data_credit_limit(pd_lim), .cpl_header_credit_limit(cplh_lim), .np_header_credit_limit(nph_lim),
        .p_header_credit_limit(ph_lim), .credit_consumed(credit_consumed), .credit_unlimited_flags(unl_flags),
        .cpl_header_buffer_capacity(cplh_cap), .cpl_payload_buffer_capacity(cpld_cap),
        .egress_word(egress_word), .egress_valid(egress_valid), .egress_packet_start(egress_packet_start),
        .egress_packet_end(egress_packet_end), .egress_upper_empty(egress_upper_empty),
        .egress_ready(egress_ready));

    task automatic check_word(input string name, input logic [67:0] exp, input logic [67:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_num(input string name, input int exp, input int got);
        tests_run++;
        if (got != exp) begin
            failures++;
            $display("Error %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // count pulses of every credit type and compare every accepted egress word
    always @(posedge mclk) begin
        if (!rst) begin
            check_word("consumed known", 68'h0, 68'($isunknown(credit_consumed)));
            for (int i = 0; i < CR_TYPES; i++) begin
                cons_cnt[i] += int'(credit_consumed[i]);
            end
            if (egress_valid === 1'b1 && egress_ready === 1'b1) begin
                check_word("egress entry", (expq.size() > 0) ? expq.pop_front() : '1,
                    {egress_upper_empty, egress_packet_start, egress_packet_end, egress_word});
            end
        end
    end

    // queue one word at the application and at the expectation
    task automatic send(input logic [63:0] w, input logic sop, input logic eop, input logic [1:0] ue);
        app.pend.push_back({ue, sop, eop, w});
        expq.push_back({ue, sop, eop, w});
    endtask

    // bounded wait until all words came out, then let late pulses land
    task automatic drain();
        int n;
        for (n = 0; n < 400 && expq.size() > 0; n++) begin
            @(posedge mclk);
        end
        if (expq.size() > 0) begin
            failures++;
            $display("Error drain timeout expected 0 seen %0d", expq.size());
            print_verdict();
        end else begin
            repeat (4) @(posedge mclk);
        end
    endtask

    task automatic check_cons(input int ph, input int pd, input int nph, input int npd, input int cplh, input int cpld);
        check_num("posted header credits", ph, cons_cnt[CR_PH]);
        check_num("posted data credits", pd, cons_cnt[CR_PD]);
        check_num("np header credits", nph, cons_cnt[CR_NPH]);
        check_num("np data credits", npd, cons_cnt[CR_NPD]);
        check_num("cpl header credits", cplh, cons_cnt[CR_CPLH]);
        check_num("cpl data credits", cpld, cons_cnt[CR_CPLD]);
        cons_cnt = '{default: 0};
    endtask

    // application side credit gate before a packet starts
    task automatic check_room(input string name, input logic [11:0] lim, input logic unl, input int need);
        check_num(name, 1, int'(unl || int'(lim) >= need));
    endtask

    // limits left at their defaults are compared with those defaults
    task automatic t_static();
        check_word("cpl data limit", 68'h040, cpld_lim);
        check_word("np data limit", 68'h010, npd_lim);
        check_word("p data limit", 68'h678, pd_lim);
        check_word("cpl hdr limit", 68'h10, cplh_lim);
        check_word("np hdr limit", 68'h34, nph_lim);
        check_word("p hdr limit", 68'h56, ph_lim);
        check_word("unlimited flags", 68'h04, unl_flags);
        check_word("cpl hdr capacity", 68'h40, cplh_cap);
        check_word("cpl data capacity", 68'hbcd, cpld_cap);
    endtask

    // three-dword write, address bit 2 set: header2 low, data0 high
    task automatic t_write_unaligned();
        check_room("posted header room", 12'(ph_lim), unl_flags[CR_PH], 1);
        check_room("posted data room", pd_lim, unl_flags[CR_PD], 1);
        send(64'h0000_00ff_4000_0001, 1'b1, 1'b0, 2'h0);
        send(64'h4433_2211_1000_0004, 1'b0, 1'b1, 2'h0);
        drain();
        check_cons(1, 1, 0, 0, 0, 0);
    endtask

    // read then completion with payload, no idle between end and start
    task automatic t_back_to_back();
        check_room("np header room", 12'(nph_lim), unl_flags[CR_NPH], 1);
        check_room("cpl header room", 12'(cplh_lim), unl_flags[CR_CPLH], 1);
        check_room("cpl data room", cpld_lim, unl_flags[CR_CPLD], 1);
        send(64'h0000_00ff_0000_0001, 1'b1, 1'b0, 2'h0);
        send(64'h5a5a_5a5a_2000_0000, 1'b0, 1'b1, 2'h0);
        send(64'h0000_0100_4a00_0002, 1'b1, 1'b0, 2'h0);
        send(64'h8765_4321_0000_0008, 1'b0, 1'b0, 2'h0);
        send(64'ha5a5_a5a5_0fed_cba9, 1'b0, 1'b1, 2'h1);
        drain();
        check_cons(0, 0, 1, 0, 1, 1);
    endtask

    // four-dword message with five payload dwords while the sink stalls
    task automatic t_message_stall();
        egress_ready = 1'b0;
        check_room("posted header room", 12'(ph_lim), unl_flags[CR_PH], 1);
        check_room("posted data room", pd_lim, unl_flags[CR_PD], 2);
        send(64'h0000_00ff_7000_0005, 1'b1, 1'b0, 2'h0);
        send(64'h0000_0000_0000_0000, 1'b0, 1'b0, 2'h0);
        send(64'h2222_2222_1111_1111, 1'b0, 1'b0, 2'h0);
        send(64'h4444_4444_3333_3333, 1'b0, 1'b0, 2'h0);
        send(64'h0000_0000_5555_5555, 1'b0, 1'b1, 2'h1);
        repeat (30) @(posedge mclk);
        #1;
        check_word("ready while full", 68'h0, transmit_ready);
        check_word("egress held", 68'h1, egress_valid);
        check_num("held words", 3, app.pend.size());
        egress_ready = 1'b1;
        drain();
        check_cons(1, 2, 0, 0, 0, 0);
    endtask

    initial begin
        cons_cnt = '{default: 0};
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        t_static();
        t_write_unaligned();
        #1;
        t_back_to_back();
        #1;
        t_message_stall();
        print_verdict();
    end
endmodule
